// ### hdl/wnps_top.sv
// wnps_top: power-up preset, nvm reload, store and restore sequencing of a 64-step wiper
// assumes two-wire bus pins and address pins are asynchronous; the nvm cell is modelled
// by a register that reset returns to NVM_INIT
//
// Summary of operation
// [R1] store into nvm commits after 26 ms
// [R2] power-on reload of wiper from nvm takes 300 us
// [R3] restore command copies nvm into wiper in 300 us
// [R4] power-up forces midscale first, then loads nvm
// [R5] master waits 540 us after preset before writing nvm
// [R6] address pins sampled once after reset and held
// [R7] serial data captured on rising serial clock
// [R8] pin states decode to one of nine addresses; only that is acknowledged
// [R9] instruction byte holds 3-bit command in upper bits, rest zero
// [R10] protect command stores nothing; data bit 0 sets or clears protection
// [R11] store and restore carry address and instruction only
// [R12] nvm operations never overlap; one later one waits, a newer one replaces it
`timescale 1ns/1ps
`default_nettype none
module wnps_top #(
  parameter int STORE_CYCLES = wnps_pkg::STORE_CYC
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // serial bus, open drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // three-state address pins: 0 low, 1 high, 2 open
  input wire logic [1:0] address_select_pin_0_in,
  input wire logic [1:0] address_select_pin_1_in,
  // status
  output logic [5:0] wiper_setting_register_out,
  output logic nvm_busy_out,
  output logic write_protect_out,
  output logic powerup_done_out
);
  typedef enum logic [4:0] {
    SQ_PRESET = 5'h01, SQ_RELOAD = 5'h02, SQ_IDLE = 5'h04, SQ_STORE = 5'h08, SQ_RESTORE = 5'h10
  } wnps_sq_st_t;

  typedef struct packed {
    logic [2:0][1:0] ad0_s;
    logic [2:0][1:0] ad1_s;
    logic [1:0] ad0_f;
    logic [1:0] ad1_f;
    wnps_sq_st_t st;
    logic [wnps_pkg::CNT_W-1:0] cnt;
    logic [5:0] wiper;
    logic [5:0] nvm;
    logic wp;
    logic [5:0] op_data;
    logic pend;
    logic [2:0] pend_code;
    logic [5:0] pend_data;
    logic [6:0] dev_addr;
    logic addr_valid;
    logic busy;
  } wnps_sq_t;

  localparam logic [wnps_pkg::CNT_W-1:0] STORE_END = wnps_pkg::CNT_W'(STORE_CYCLES - 1);
  localparam logic [wnps_pkg::CNT_W-1:0] RELOAD_END = wnps_pkg::CNT_W'(wnps_pkg::RELOAD_CYC - 1);
  localparam logic [wnps_pkg::CNT_W-1:0] RESTORE_END = wnps_pkg::CNT_W'(wnps_pkg::RESTORE_CYC - 1);
  localparam logic [wnps_pkg::CNT_W-1:0] PRESET_END = wnps_pkg::CNT_W'(wnps_pkg::PRESET_CYC - 1);

  wnps_sq_t r;
  wnps_sq_t next_r;
  wnps_link_if lnk ();

  wnps_i2c_slave u_rx (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_out(sda_oe_out),
    .lnk(lnk.rx)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.ad0_s = {r.ad0_s[1:0], address_select_pin_0_in};
    next_r.ad1_s = {r.ad1_s[1:0], address_select_pin_1_in};
    if (r.ad0_s[1] == r.ad0_s[2]) begin
      next_r.ad0_f = r.ad0_s[2];
    end
    if (r.ad1_s[1] == r.ad1_s[2]) begin
      next_r.ad1_f = r.ad1_s[2];
    end
    next_r.cnt = r.cnt + wnps_pkg::CNT_W'(1);
    case (r.st)
      SQ_PRESET: begin
        // [R4] midscale before nvm load
        next_r.wiper = wnps_pkg::MIDSCALE;
        if (r.cnt == PRESET_END) begin
          // [R6] one-time address capture
          next_r.dev_addr = wnps_pkg::slave_addr(r.ad1_f, r.ad0_f);
          next_r.addr_valid = 1'b1;
          next_r.cnt = '0;
          next_r.st = SQ_RELOAD;
        end
      end
      SQ_RELOAD: begin
        // [R2] power-on reload time
        if (r.cnt == RELOAD_END) begin
          next_r.wiper = r.nvm;
          next_r.cnt = '0;
          next_r.st = SQ_IDLE;
        end
      end
      SQ_IDLE: begin
        next_r.cnt = '0;
        // [R12] start one waiting operation
        if (r.pend) begin
          next_r.pend = 1'b0;
          if (r.pend_code == wnps_pkg::CMD_RESTORE) begin
            next_r.st = SQ_RESTORE;
          end else if (!r.wp) begin
            next_r.op_data = (r.pend_code == wnps_pkg::CMD_STORE) ? r.wiper : r.pend_data;
            next_r.st = SQ_STORE;
          end
        end
      end
      SQ_STORE: begin
        // [R1] commit after store time
        if (r.cnt == STORE_END) begin
          next_r.nvm = r.op_data;
          next_r.cnt = '0;
          next_r.st = SQ_IDLE;
        end
      end
      SQ_RESTORE: begin
        // [R3] restore time
        if (r.cnt == RESTORE_END) begin
          next_r.wiper = r.nvm;
          next_r.cnt = '0;
          next_r.st = SQ_IDLE;
        end
      end
      default: begin
        next_r.st = SQ_PRESET;
      end
    endcase
    // store, restore and nvm write commands arriving during an operation overwrite the single waiting slot; wiper and protect writes act at once
    if (lnk.cmd_valid) begin
      if (lnk.cmd_code == wnps_pkg::CMD_WR_WIPER) begin
        next_r.wiper = lnk.cmd_data[5:0];
      end else if (lnk.cmd_code == wnps_pkg::CMD_WR_PROT) begin
        // [R10] protect flag from bit 0
        next_r.wp = lnk.cmd_data[0];
      end else begin
        next_r.pend = 1'b1;
        next_r.pend_code = lnk.cmd_code;
        next_r.pend_data = lnk.cmd_data[5:0];
      end
    end
    next_r.busy = (next_r.st != SQ_IDLE);
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '{ad0_s: '0, ad1_s: '0, ad0_f: wnps_pkg::PIN_LOW, ad1_f: wnps_pkg::PIN_LOW, st: SQ_PRESET,
             cnt: '0, wiper: wnps_pkg::MIDSCALE, nvm: wnps_pkg::NVM_INIT, wp: 1'b0, op_data: 6'h00,
             pend: 1'b0, pend_code: 3'h0, pend_data: 6'h00, dev_addr: 7'h00, addr_valid: 1'b0,
             busy: 1'b1};
    end else begin
      r <= next_r;
    end
  end

  assign lnk.wiper = r.wiper;
  assign lnk.dev_addr = r.dev_addr;
  assign lnk.addr_valid = r.addr_valid;
  assign sda_out = 1'b0;
  assign wiper_setting_register_out = r.wiper;
  assign nvm_busy_out = r.busy;
  assign write_protect_out = r.wp;
  assign powerup_done_out = r.addr_valid;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence reload_end_s;
    r.st == SQ_RELOAD && r.cnt == RELOAD_END;
  endsequence
  sequence store_end_s;
    r.st == SQ_STORE && r.cnt == STORE_END;
  endsequence

  // wiper writes are legal during reload, so only preset and the first reload cycle are held
  preset_midscale_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R4]
    (r.st == SQ_PRESET || (r.st == SQ_RELOAD && $past(r.st) == SQ_PRESET)) |-> r.wiper == wnps_pkg::MIDSCALE)
    else $error("wiper not at midscale before reload");
  reload_load_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R2]
    reload_end_s ##0 !lnk.cmd_valid |=> r.st == SQ_IDLE && r.wiper == $past(r.nvm))
    else $error("reload did not load nvm on time");
  reload_len_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R2]
    (r.st == SQ_RELOAD && $past(r.st) == SQ_PRESET) |-> r.cnt == '0)
    else $error("reload count not started from zero");
  store_commit_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R1]
    store_end_s |=> r.nvm == $past(r.op_data) && r.st == SQ_IDLE)
    else $error("store did not commit at its end");
  nvm_only_end_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R1]
    !$stable(r.nvm) |-> $past(r.st) == SQ_STORE && $past(r.cnt) == STORE_END)
    else $error("nvm changed outside store completion");
  restore_time_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R3]
    (r.st == SQ_RESTORE && r.cnt == RESTORE_END && !lnk.cmd_valid) |=> r.wiper == $past(r.nvm))
    else $error("restore did not copy nvm");
  prot_blocks_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R10]
    (r.st == SQ_IDLE && r.pend && r.wp && r.pend_code != wnps_pkg::CMD_RESTORE) |=> r.st == SQ_IDLE)
    else $error("nvm write started while protected");
  addr_held_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R6]
    $past(r.addr_valid) |-> $stable(r.dev_addr) && r.addr_valid)
    else $error("sampled address changed");
  no_overlap_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R12]
    (r.st == SQ_STORE && r.cnt != STORE_END) |=> r.st == SQ_STORE)
    else $error("store interrupted by another operation");
endmodule
`default_nettype wire

// ### hdl/wnps_pkg.sv
// wnps_pkg: constants, command codes and timing for the wiper nvm sequencer
// assumes a single 10 MHz system clock; no registers reachable by software
package wnps_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int STORE_TIME_MS = 26;
  localparam int RELOAD_TIME_US = 300;
  localparam int RESTORE_TIME_US = 300;
  localparam int REWRITE_TIME_US = 540;
  localparam int STORE_CYC = STORE_TIME_MS * (CLK_HZ / 1000);
  localparam int RELOAD_CYC = RELOAD_TIME_US * (CLK_HZ / 1_000_000);
  localparam int RESTORE_CYC = RESTORE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int REWRITE_CYC = REWRITE_TIME_US * (CLK_HZ / 1_000_000);
  // preset hold covers the pin synchroniser filling up
  localparam int PRESET_CYC = 8;
  localparam int CNT_W = 19;

  // ----------------------------------------------------------------
  // wiper and address
  // ----------------------------------------------------------------
  localparam int WIPER_W = 6;
  localparam logic [5:0] MIDSCALE = 6'h20;
  localparam logic [5:0] NVM_INIT = 6'h20;
  localparam logic [6:0] ADDR_BASE = 7'h18;
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_HIGH = 2'h1;
  localparam logic [1:0] PIN_OPEN = 2'h2;

  // ----------------------------------------------------------------
  // instruction command field
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_WR_WIPER = 3'h0;
  localparam logic [2:0] CMD_WR_NVM = 3'h1;
  localparam logic [2:0] CMD_WR_PROT = 3'h2;
  localparam logic [2:0] CMD_STORE = 3'h5;
  localparam logic [2:0] CMD_RESTORE = 3'h6;

  // nine addresses: base + 3 * pin1 + pin0, codes above PIN_OPEN count as open
  function automatic logic [6:0] slave_addr(input logic [1:0] p1, input logic [1:0] p0);
    logic [6:0] a1;
    logic [6:0] a0;
    a1 = (p1 > PIN_OPEN) ? 7'h2 : {5'h0, p1};
    a0 = (p0 > PIN_OPEN) ? 7'h2 : {5'h0, p0};
    slave_addr = ADDR_BASE + a1 + a1 + a1 + a0;
  endfunction
endpackage

// ### hdl/wnps_link_if.sv
// wnps_link_if: commands from the serial front end to the sequencer
// assumes both ends run on ref_clk_in
`timescale 1ns/1ps
`default_nettype none
interface wnps_link_if;
  logic cmd_valid;
  logic [2:0] cmd_code;
  logic [7:0] cmd_data;
  logic [5:0] wiper;
  logic [6:0] dev_addr;
  logic addr_valid;
  modport rx (output cmd_valid, output cmd_code, output cmd_data,
              input wiper, input dev_addr, input addr_valid);
  modport seq (input cmd_valid, input cmd_code, input cmd_data,
               output wiper, output dev_addr, output addr_valid);
endinterface
`default_nettype wire

// ### hdl/wnps_i2c_slave.sv
// wnps_i2c_slave: two-wire slave front end, oversampled by ref_clk_in
// assumes serial clock well below clock / 8; open-drain data driven low only
`timescale 1ns/1ps
`default_nettype none
module wnps_i2c_slave (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_out,
  // to sequencer
  wnps_link_if.rx lnk
);
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_BYTE = 5'h02, RX_ACK = 5'h04, RX_TX = 5'h08, RX_RACK = 5'h10
  } wnps_rx_st_t;

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
    wnps_rx_st_t st;
    logic [3:0] cnt;
    logic [1:0] idx;
    logic [7:0] sh;
    logic rw;
    logic [2:0] code;
    logic oe;
    logic cv;
    logic [2:0] cc;
    logic [7:0] cd;
  } wnps_rx_t;

  wnps_rx_t r;
  wnps_rx_t next_r;

  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    next_r = r;
    next_r.cv = 1'b0;
    next_r.scl_s = {r.scl_s[1:0], scl_in};
    next_r.sda_s = {r.sda_s[1:0], sda_in};
    if (r.scl_s[1] == r.scl_s[2]) begin
      next_r.scl_f = r.scl_s[2];
    end
    if (r.sda_s[1] == r.sda_s[2]) begin
      next_r.sda_f = r.sda_s[2];
    end
    rise = next_r.scl_f & ~r.scl_f;
    fall = ~next_r.scl_f & r.scl_f;
    start = r.scl_f & next_r.scl_f & r.sda_f & ~next_r.sda_f;
    stop = r.scl_f & next_r.scl_f & ~r.sda_f & next_r.sda_f;
    if (start) begin
      next_r.st = RX_BYTE;
      next_r.cnt = 4'h0;
      next_r.idx = 2'h0;
      next_r.oe = 1'b0;
    end else if (stop) begin
      next_r.st = RX_IDLE;
      next_r.oe = 1'b0;
    end else begin
      case (r.st)
        RX_BYTE: begin
          // [R7] sample on rising clock
          if (rise && r.cnt < 4'h8) begin
            next_r.sh = {r.sh[6:0], r.sda_f};
            next_r.cnt = r.cnt + 4'h1;
          end else if (fall && r.cnt == 4'h8) begin
            if (r.idx == 2'h0) begin
              // [R8] acknowledge own address
              if (lnk.addr_valid && r.sh[7:1] == lnk.dev_addr) begin
                next_r.rw = r.sh[0];
                next_r.oe = 1'b1;
                next_r.st = RX_ACK;
              end else begin
                next_r.st = RX_IDLE;
              end
            end else if (r.idx == 2'h1) begin
              // [R9] command in upper three bits
              next_r.code = r.sh[7:5];
              next_r.oe = 1'b1;
              next_r.st = RX_ACK;
              // [R11] store and restore need no data
              if (r.sh[7:5] == wnps_pkg::CMD_STORE || r.sh[7:5] == wnps_pkg::CMD_RESTORE) begin
                next_r.cv = 1'b1;
                next_r.cc = r.sh[7:5];
              end
            end else begin
              next_r.oe = 1'b1;
              next_r.st = RX_ACK;
              if (r.code == wnps_pkg::CMD_WR_WIPER || r.code == wnps_pkg::CMD_WR_NVM ||
                  r.code == wnps_pkg::CMD_WR_PROT) begin
                next_r.cv = 1'b1;
                next_r.cc = r.code;
                next_r.cd = r.sh;
              end
            end
          end
        end
        RX_ACK: begin
          if (fall) begin
            next_r.cnt = 4'h0;
            if (r.rw) begin
              next_r.sh = {2'h0, lnk.wiper};
              next_r.oe = 1'b1;
              next_r.st = RX_TX;
            end else begin
              next_r.oe = 1'b0;
              next_r.st = RX_BYTE;
              if (r.idx != 2'h2) begin
                next_r.idx = r.idx + 2'h1;
              end
            end
          end
        end
        RX_TX: begin
          if (fall) begin
            if (r.cnt == 4'h7) begin
              next_r.oe = 1'b0;
              next_r.st = RX_RACK;
            end else begin
              next_r.sh = {r.sh[6:0], 1'b0};
              next_r.cnt = r.cnt + 4'h1;
              next_r.oe = ~r.sh[6];
            end
          end
        end
        RX_RACK: begin
          // one byte per read; the rest waits for a new start
          if (rise) begin
            next_r.st = RX_IDLE;
          end
        end
        default: begin
          next_r.st = RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1, st: RX_IDLE, cnt: 4'h0,
             idx: 2'h0, sh: 8'h00, rw: 1'b0, code: 3'h0, oe: 1'b0, cv: 1'b0, cc: 3'h0, cd: 8'h00};
    end else begin
      r <= next_r;
    end
  end

  assign sda_oe_out = r.oe;
  assign lnk.cmd_valid = r.cv;
  assign lnk.cmd_code = r.cc;
  assign lnk.cmd_data = r.cd;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  addr_ack_own_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R8]
    (r.st == RX_BYTE && r.idx == 2'h0 && next_r.st == RX_ACK) |-> r.sh[7:1] == lnk.dev_addr)
    else $error("address acknowledged that is not ours");
  rise_sample_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R7]
    (r.st == RX_BYTE && r.cnt < 4'h8 && !r.scl_f && next_r.scl_f && !next_r.sda_f && !(r.sda_f && r.scl_f))
    |=> r.sh[0] == $past(r.sda_f))
    else $error("data bit not taken on clock rise");
  nodata_cmd_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R11]
    (r.cv && (r.cc == wnps_pkg::CMD_STORE || r.cc == wnps_pkg::CMD_RESTORE)) |-> r.idx == 2'h1)
    else $error("store or restore issued after a data byte");
endmodule
`default_nettype wire

// ### verification/wnps_master_model.sv
// wnps_master_model: behavioural two-wire bus master for the wiper sequencer bench
// assumes a pull-up on the data line and a clock far faster than the serial clock
`timescale 1ns/1ps
`default_nettype none
module wnps_master_model (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // serial bus
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  // quarter bit of 7 clocks keeps the serial clock near 357 kHz
  localparam int Q = 7;
  int since_rel;

  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in)
      since_rel <= 0;
    else if (since_rel < 1000000)
      since_rel <= since_rel + 1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  // data moves only while scl low
  task automatic bit_io(input logic b, output logic r);
    sda_oe_out <= ~b;
    wt(Q);
    scl_out <= 1'b1;
    wt(Q);
    r = sda_in;
    wt(Q);
    scl_out <= 1'b0;
    wt(Q);
  endtask

  task automatic byte_io(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // command in upper bits, no data for store or restore
  task automatic xfer(input logic [6:0] addr, input logic [2:0] cmd, input logic [7:0] data, output logic acked);
    logic a;
    // nvm writes wait out the holdoff after preset
    while (cmd == wnps_pkg::CMD_WR_NVM && since_rel < wnps_pkg::PRESET_CYC + wnps_pkg::REWRITE_CYC)
      wt(1);
    sda_oe_out <= 1'b1;
    wt(Q);
    scl_out <= 1'b0;
    wt(Q);
    byte_io({addr, 1'b0}, acked);
    if (acked) begin
      byte_io({cmd, 5'h00}, a);
      acked = a;
      if (cmd != wnps_pkg::CMD_STORE && cmd != wnps_pkg::CMD_RESTORE) begin
        byte_io(data, a);
        acked = acked & a;
      end
    end
    sda_oe_out <= 1'b1;
    wt(Q);
    scl_out <= 1'b1;
    wt(Q);
    sda_oe_out <= 1'b0;
    wt(2 * Q);
  endtask
endmodule
`default_nettype wire

// ### verification/wnps_top_tb_top.sv
// wnps_top_tb_top: self-checking bench for the wiper power-up and nvm sequencer
// assumes the master model on the serial pins and a shortened store time
`timescale 1ns/1ps
`default_nettype none
module wnps_top_tb_top;
  localparam int STORE_N = 2000;
  localparam int LIMIT = 95000;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [1:0] pin0 = 2'h0;
  logic [1:0] pin1 = 2'h0;
  logic scl, m_oe, sda_d, oe_d, busy, prot, done;
  logic [5:0] wiper;
  wire logic sda_line;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int busy_run = 0;
  int last_run = 0;
  logic [31:0] seed;

  always #50 ref_clk_in = ~ref_clk_in;
  // open drain: pull-up unless someone pulls low
  assign sda_line = (oe_d ? sda_d : 1'b1) & ~m_oe;

  wnps_top #(.STORE_CYCLES(STORE_N)) i_wnps_top (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_d), .sda_oe_out(oe_d),
    .address_select_pin_0_in(pin0), .address_select_pin_1_in(pin1),
    .wiper_setting_register_out(wiper), .nvm_busy_out(busy),
    .write_protect_out(prot), .powerup_done_out(done)
  );

  wnps_master_model i_wnps_master_model (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .sda_in(sda_line), .scl_out(scl), .sda_oe_out(m_oe)
  );

  // ----
  // checking helpers
  // ----
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  // cycle figures allow a few clocks of pin synchroniser slack
  task automatic chk_near(input string what, input int exp, input int got);
    check_count++;
    if (got < exp - 3 || got > exp + 3) begin
      err_total++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask

  function automatic logic [6:0] exp_addr(input logic [1:0] a1, input logic [1:0] a0);
    return wnps_pkg::ADDR_BASE + 7'(3 * a1) + 7'(a0);
  endfunction

  task automatic test_done;
    $display("checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      test_done();
    end
  end

  // length of the latest busy stretch
  always @(posedge ref_clk_in) begin
    if (rst_in)
      busy_run <= 0;
    else if (busy === 1'b1)
      busy_run <= busy_run + 1;
    else begin
      if (busy_run != 0)
        last_run <= busy_run;
      busy_run <= 0;
    end
  end

  // a dip of one clock between queued operations is not idle
  task automatic wait_idle;
    int n;
    n = 0;
    while (n < 4) begin
      @(posedge ref_clk_in);
      n = (busy === 1'b0) ? n + 1 : 0;
    end
  endtask

  task automatic do_reset(input logic [1:0] a1, input logic [1:0] a0);
    rst_in <= 1'b1;
    pin1 <= a1;
    pin0 <= a0;
    repeat (16) @(posedge ref_clk_in);
    chk("wiper in reset", wnps_pkg::MIDSCALE, wiper);
    chk("busy in reset", 1, busy);
    rst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    chk("wiper in preset", wnps_pkg::MIDSCALE, wiper);
    chk("done in preset", 0, done);
    wait_idle();
    chk_near("reload time", wnps_pkg::PRESET_CYC + wnps_pkg::RELOAD_CYC, last_run);
    chk("wiper after reload", wnps_pkg::NVM_INIT, wiper);
    chk("powerup done", 1, done);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    logic [6:0] own;
    logic [5:0] n, s, t, m;
    logic [1:0] a0, a1;
    logic ack;
    seed = $urandom(32'h72a1);
    for (int k = 0; k < 2; k++) begin
      a1 = (k == 0) ? 2'h2 : 2'($urandom % 3);
      a0 = (k == 0) ? 2'h2 : 2'($urandom % 3);
      do_reset(a1, a0);
      own = exp_addr(a1, a0);
      pin1 <= a1 + 2'h1;
      pin0 <= 2'($urandom);
      n = 6'($urandom);
      s = 6'($urandom);
      t = ~s;
      m = ~n;
      i_wnps_master_model.xfer(own ^ 7'h01, wnps_pkg::CMD_WR_WIPER, 8'h3F, ack);
      chk("foreign ack", 0, ack);
      chk("wiper kept", wnps_pkg::NVM_INIT, wiper);
      i_wnps_master_model.xfer(own, wnps_pkg::CMD_WR_NVM, {2'h0, n}, ack);
      chk("own ack", 1, ack);
      wait_idle();
      i_wnps_master_model.xfer(own, wnps_pkg::CMD_WR_WIPER, {2'h3, m}, ack);
      chk("wiper write", m, wiper);
      i_wnps_master_model.xfer(own, wnps_pkg::CMD_RESTORE, 8'h00, ack);
      wait_idle();
      chk_near("restore time", wnps_pkg::RESTORE_CYC, last_run);
      chk("wiper restored", n, wiper);
      i_wnps_master_model.xfer(own, wnps_pkg::CMD_WR_WIPER, {2'h0, s}, ack);
      i_wnps_master_model.xfer(own, wnps_pkg::CMD_STORE, 8'h00, ack);
      chk("store ack", 1, ack);
      wait_idle();
      chk_near("store time", STORE_N, last_run);
      // restore queued behind a store must bring back t, not the later write of s
      i_wnps_master_model.xfer(own, wnps_pkg::CMD_WR_WIPER, {2'h0, t}, ack);
      i_wnps_master_model.xfer(own, wnps_pkg::CMD_STORE, 8'h00, ack);
      i_wnps_master_model.xfer(own, wnps_pkg::CMD_WR_WIPER, {2'h0, s}, ack);
      chk("wiper during store", s, wiper);
      i_wnps_master_model.xfer(own, wnps_pkg::CMD_RESTORE, 8'h00, ack);
      chk("busy queued", 1, busy);
      wait_idle();
      chk("wiper after queue", t, wiper);
      i_wnps_master_model.xfer(own, wnps_pkg::CMD_WR_PROT, 8'h01, ack);
      chk("protect on", 1, prot);
      chk("wiper after protect", t, wiper);
      i_wnps_master_model.xfer(own, wnps_pkg::CMD_WR_WIPER, {2'h0, s}, ack);
      i_wnps_master_model.xfer(own, wnps_pkg::CMD_STORE, 8'h00, ack);
      chk("busy while protected", 0, busy);
      i_wnps_master_model.xfer(own, wnps_pkg::CMD_RESTORE, 8'h00, ack);
      wait_idle();
      chk("nvm kept", t, wiper);
      i_wnps_master_model.xfer(own, wnps_pkg::CMD_WR_PROT, 8'hFE, ack);
      chk("protect off", 0, prot);
    end
    test_done();
  end
endmodule
`default_nettype wire
